/* File: bench/pfif_host.sv */
/*
  Host model: drives the register port of the interrupt flag block.
  Assumes the bench supplies the clock and calls the tasks serially.
*/
`timescale 1ns/1ps
`default_nettype none

module pfif_host (
  // Clock
  input wire logic sys_clk,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
  endtask
endmodule

`default_nettype wire

/* File: bench/pfif_top_tb.sv */
/*
  Self-checking bench of the power fault interrupt flag block.
  Assumes the design files and the host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pfif_map.svh"

module pfif_top_tb;
  logic sys_clk, rst, reg_wr, reg_rd, int_n;
  logic rd_p = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, supply_fault_in;
  logic [7:0] charger_state_reg, p, f;
  logic general_pin_one, general_pin_two, adc_done, analog_sense_hiz;
  logic thermal_fault, conv_above_limit, conv_below_limit;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h3B63D2B6;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;

  pfif_top DUT (.sys_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .supply_fault_in, .general_pin_one, .general_pin_two,
    .adc_done, .analog_sense_hiz, .thermal_fault, .conv_above_limit,
    .conv_below_limit, .charger_state_reg, .int_n);
  pfif_host host (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic check(input string n, input logic [7:0] s,
                       input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask

  // Samples the line half a cycle after the edge that launched it
  task automatic irq(input logic e);
    @(negedge sys_clk);
    check("int_n", {7'h00, int_n}, {7'h00, e});
  endtask

  // Pulses or toggles one event source, then lets the flag and line settle
  task automatic fire(input int i);
    @(posedge sys_clk);
    case (i)
      `PFIF_B_ADC_DONE: adc_done <= 1'b1;
      `PFIF_B_ANALOG_HIZ: analog_sense_hiz <= 1'b1;
      `PFIF_B_PIN_TWO: general_pin_two <= ~general_pin_two;
      `PFIF_B_PIN_ONE: general_pin_one <= ~general_pin_one;
      `PFIF_B_THERMAL: thermal_fault <= 1'b1;
      `PFIF_B_CHARGER: charger_state_reg <= charger_state_reg ^ 8'h01;
      `PFIF_B_CONV_HI: conv_above_limit <= 1'b1;
      default: conv_below_limit <= 1'b1;
    endcase
    @(posedge sys_clk);
    {adc_done, analog_sense_hiz, thermal_fault} <= 3'b000;
    {conv_above_limit, conv_below_limit} <= 2'b00;
    repeat (6) @(posedge sys_clk);
  endtask

  // read results leave the queue in order
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (rd_p) check("reg_rdata", reg_rdata, exp_q.pop_front());
    rd_p <= reg_rd;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    supply_fault_in = 8'h00;
    charger_state_reg = 8'h00;
    {general_pin_one, general_pin_two, adc_done} = 3'b000;
    {analog_sense_hiz, thermal_fault} = 2'b00;
    {conv_above_limit, conv_below_limit} = 2'b00;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    for (int a = 3; a < 8; a++) rd(a[7:0], 8'h00);
    rd(8'h10, 8'h00);
    irq(1'b1);
    $display("Test reset values done");
    p = rnd();
    host.wr(`PFIF_ADDR_MASK2, p);
    rd(`PFIF_ADDR_MASK2, p);
    host.wr(`PFIF_ADDR_MASK2, 8'h00);
    for (int i = 0; i < 8; i++) begin
      fire(i);
      irq(1'b0);
      rd(`PFIF_ADDR_ACK2, 8'h01 << i);
      repeat (3) @(posedge sys_clk);
      irq(1'b1);
    end
    $display("Test event sources done");
    host.wr(`PFIF_ADDR_MASK2, 8'h10);
    fire(`PFIF_B_PIN_ONE);
    irq(1'b1);
    rd(`PFIF_ADDR_ACK2, 8'h10);
    host.wr(`PFIF_ADDR_MASK2, 8'h00);
    host.wr(`PFIF_ADDR_ACK2, 8'hFF);
    @(posedge sys_clk);
    charger_state_reg <= charger_state_reg ^ 8'h80;
    repeat (6) @(posedge sys_clk);
    irq(1'b1);
    rd(`PFIF_ADDR_ACK2, 8'h00);
    $display("Test masking done");
    for (int k = 0; k < 5; k++) begin
      p = (k == 0) ? 8'h00 : rnd();
      f = (k == 0) ? 8'h20 : rnd();
      host.wr(`PFIF_ADDR_PGMASK, p);
      rd(`PFIF_ADDR_PGMASK, p);
      @(posedge sys_clk);
      supply_fault_in <= f;
      repeat (6) @(posedge sys_clk);
      irq((f & ~p) == 8'h00);
      rd(`PFIF_ADDR_ACK1, f & ~p);
      host.wr(`PFIF_ADDR_ACK1, 8'h00);
      host.wr(`PFIF_ADDR_ACK1, 8'hFF);
      rd(`PFIF_ADDR_ACK1, 8'h00);
      supply_fault_in <= 8'h00;
      repeat (3) @(posedge sys_clk);
      irq(1'b1);
    end
    $display("Test supply faults done");
    host.wr(`PFIF_ADDR_MASK1, 8'h20);
    rd(`PFIF_ADDR_MASK1, 8'h20);
    host.wr(`PFIF_ADDR_PGMASK, 8'h00);
    @(posedge sys_clk);
    supply_fault_in <= 8'h20;
    repeat (6) @(posedge sys_clk);
    irq(1'b1);
    rd(`PFIF_ADDR_ACK1, 8'h20);
    host.wr(`PFIF_ADDR_MASK1, 8'h00);
    repeat (2) @(posedge sys_clk);
    irq(1'b0);
    host.wr(`PFIF_ADDR_ACK1, 8'h00);
    supply_fault_in <= 8'h00;
    repeat (3) @(posedge sys_clk);
    irq(1'b1);
    $display("Test supply mask done");
    give_verdict();
  end
endmodule

`default_nettype wire

/* File: design/pfif_map.svh */
/*
  Register offsets, bit positions and reset values of the power fault
  interrupt flag block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef PFIF_MAP_SVH
`define PFIF_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PFIF_ADDR_MASK1 8'h03
`define PFIF_ADDR_MASK2 8'h04
`define PFIF_ADDR_ACK1 8'h05
`define PFIF_ADDR_ACK2 8'h06
`define PFIF_ADDR_PGMASK 8'h07

// ****************************************************************
// Reset values
// ****************************************************************
`define PFIF_RST_MASK1 8'h00
`define PFIF_RST_MASK2 8'h00
`define PFIF_RST_ACK 8'h00
`define PFIF_RST_PGMASK 8'h00
`define PFIF_RDATA_NONE 8'h00

// ****************************************************************
// Bit positions in the event mask and misc flags
// ****************************************************************
`define PFIF_B_ADC_DONE 7
`define PFIF_B_ANALOG_HIZ 6
`define PFIF_B_PIN_TWO 5
`define PFIF_B_PIN_ONE 4
`define PFIF_B_THERMAL 3
`define PFIF_B_CHARGER 2
`define PFIF_B_CONV_HI 1
`define PFIF_B_CONV_LO 0

// Supply flags: boost converter slot records over-voltage
`define PFIF_B_BOOST_THREE 5
// Charger state: battery discharge bit never raises an event
`define PFIF_B_BAT_DISCH 7

`endif

/* File: design/pfif_pkg.sv */
/*
  Types shared by the power fault interrupt flag block.
  Assumes nothing of its surroundings.
*/
package pfif_pkg;
  typedef logic [7:0] pfif_byte_t;
  typedef logic [9:0] pfif_pins_t;
endpackage

/* File: design/pfif_sync_edge.sv */
/*
  Two-stage synchroniser with rise and any-edge detection per bit.
  Assumes asynchronous inputs and a single system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pfif_sync_edge #(
  parameter int W = 10
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Asynchronous levels
  input wire logic [W-1:0] async_in,
  // Synchronised outputs
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] edge_any
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  // ****************************************************************
  // Synchroniser and history
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise = sync_r & ~prev_r;
  assign edge_any = sync_r ^ prev_r;

endmodule

`default_nettype wire

/* File: design/pfif_top.sv */
/*
  Interrupt flags, masks and power-good fault mask of a power manager.
  Assumes a register port fed by the serial host interface, internal
  event sources on sys_clk, and fault and pin levels from outside.
*/
// Contract
// (RL1) Event mask two readable, one blocks source
// (RL2) Pin edges set own flag, maskable
// (RL3) Supply faults set flags; host writes zero
// (RL4) Boost converter flag records over-voltage fault
// (RL5) Misc flags read-only, set by events
// (RL6) Fault mask excludes supply from reporting
// (RL7) Interrupt line driven low on request
// (RL8) Battery discharge bit never raises interrupt
// (RL9) Line low while any unmasked flag set
`timescale 1ns/1ps
`default_nettype none
`include "pfif_map.svh"

module pfif_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Supply fault levels, bit 5 is boost over-voltage
  input wire logic [7:0] supply_fault_in,
  // General purpose pins
  input wire logic general_pin_one,
  input wire logic general_pin_two,
  // Internal event sources on sys_clk
  input wire logic adc_done,
  input wire logic analog_sense_hiz,
  input wire logic thermal_fault,
  input wire logic conv_above_limit,
  input wire logic conv_below_limit,
  input wire logic [7:0] charger_state_reg,
  // Host interrupt, active low
  output logic int_n
);

  pfif_pkg::pfif_byte_t mask1_r, mask2_r, pgmask_r;
  pfif_pkg::pfif_byte_t ack1_r, ack1_nxt, ack2_r, ack2_nxt;
  pfif_pkg::pfif_byte_t rdata_r, rdata_nxt;
  pfif_pkg::pfif_byte_t chg_prev_r, src_prev_r;
  pfif_pkg::pfif_byte_t sup_rise, ack1_set, ack2_set, src_now;
  pfif_pkg::pfif_byte_t ack1_keep, ack2_keep;
  pfif_pkg::pfif_pins_t pin_level, pin_rise, pin_edge;
  logic int_n_r;
  logic pending;
  logic charger_change;

  function automatic logic hit(input logic acc, input logic [7:0] a,
                               input logic [7:0] off);
    hit = acc && (a == off);
  endfunction

  // ****************************************************************
  // Synchronise outside levels
  // ****************************************************************
  pfif_sync_edge #(.W(10)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in({general_pin_two, general_pin_one, supply_fault_in}),
    .level(pin_level),
    .rise(pin_rise),
    .edge_any(pin_edge)
  );

  // ****************************************************************
  // Event detection
  // ****************************************************************
  // (RL3) (RL4) (RL6) Unmasked supply fault rise sets flag
  assign sup_rise = pin_rise[7:0];
  assign ack1_set = sup_rise & ~pgmask_r;

  // (RL8) Charger change ignores discharge bit
  assign charger_change =
    |((charger_state_reg ^ chg_prev_r) &
      ~(8'h01 << `PFIF_B_BAT_DISCH));

  assign src_now = {adc_done, analog_sense_hiz, 2'b00, thermal_fault,
                    1'b0, conv_above_limit, conv_below_limit};

  // (RL2) (RL5) Misc flags set on event edges
  assign ack2_set = (src_now & ~src_prev_r) |
                    ({2'b00, pin_edge[9], pin_edge[8], 4'h0}) |
                    ({5'h00, charger_change, 2'b00});

  // ****************************************************************
  // Flag update, set wins over clear
  // ****************************************************************
  // (RL3) Host clears supply flag by writing zero
  assign ack1_keep = hit(reg_wr, reg_addr, `PFIF_ADDR_ACK1) ?
                     reg_wdata : 8'hFF;
  assign ack1_nxt = ack1_set | (ack1_r & ack1_keep);
  // (RL5) Misc flags read-only, cleared by reading
  assign ack2_keep = hit(reg_rd, reg_addr, `PFIF_ADDR_ACK2) ?
                     8'h00 : 8'hFF;
  assign ack2_nxt = ack2_set | (ack2_r & ack2_keep);

  // (RL9) Pending when any unmasked flag stands
  assign pending = |(ack1_r & ~mask1_r) | |(ack2_r & ~mask2_r);

  // ****************************************************************
  // Read mux
  // ****************************************************************
  assign rdata_nxt =
    (reg_addr == `PFIF_ADDR_MASK1)  ? mask1_r :
    (reg_addr == `PFIF_ADDR_MASK2)  ? mask2_r :
    (reg_addr == `PFIF_ADDR_ACK1)   ? ack1_r :
    (reg_addr == `PFIF_ADDR_ACK2)   ? ack2_r :
    (reg_addr == `PFIF_ADDR_PGMASK) ? pgmask_r : `PFIF_RDATA_NONE;

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask1_r <= `PFIF_RST_MASK1;
      mask2_r <= `PFIF_RST_MASK2;
      pgmask_r <= `PFIF_RST_PGMASK;
    end else begin
      if (hit(reg_wr, reg_addr, `PFIF_ADDR_MASK1)) begin
        mask1_r <= reg_wdata;
      end
      // (RL1) Host writes event mask two
      if (hit(reg_wr, reg_addr, `PFIF_ADDR_MASK2)) begin
        mask2_r <= reg_wdata;
      end
      // (RL6) Host writes fault mask
      if (hit(reg_wr, reg_addr, `PFIF_ADDR_PGMASK)) begin
        pgmask_r <= reg_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack1_r <= `PFIF_RST_ACK;
      ack2_r <= `PFIF_RST_ACK;
      chg_prev_r <= 8'h00;
      src_prev_r <= 8'h00;
    end else begin
      ack1_r <= ack1_nxt;
      ack2_r <= ack2_nxt;
      chg_prev_r <= charger_state_reg;
      src_prev_r <= src_now;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= `PFIF_RDATA_NONE;
      int_n_r <= 1'b1;
    end else begin
      if (reg_rd) begin
        rdata_r <= rdata_nxt;
      end
      // (RL7) Line goes low on pending request
      int_n_r <= ~pending;
    end
  end

  assign reg_rdata = rdata_r;
  assign int_n = int_n_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_mask2_write: assert property ( // (RL1)
    @(posedge sys_clk) disable iff (rst)
    hit(reg_wr, reg_addr, `PFIF_ADDR_MASK2) |=> mask2_r == $past(reg_wdata))
    else $error("event mask two not stored");

  a_mask2_blocks: assert property ( // (RL1)
    @(posedge sys_clk) disable iff (rst)
    (ack1_r == 8'h00 && (ack2_r & ~mask2_r) == 8'h00) |=> int_n)
    else $error("masked misc flag raised interrupt");

  a_pin_edge_flag: assert property ( // (RL2)
    @(posedge sys_clk) disable iff (rst)
    (pin_edge[8] || pin_edge[9]) |=>
      (ack2_r[`PFIF_B_PIN_ONE] || !$past(pin_edge[8])) &&
      (ack2_r[`PFIF_B_PIN_TWO] || !$past(pin_edge[9])))
    else $error("pin edge did not set its flag");

  a_ack1_clear: assert property ( // (RL3)
    @(posedge sys_clk) disable iff (rst)
    (hit(reg_wr, reg_addr, `PFIF_ADDR_ACK1) && ack1_set == 8'h00) |=>
      ack1_r == ($past(ack1_r) & $past(reg_wdata)))
    else $error("supply flag write-zero clear wrong");

  a_boost_ovp: assert property ( // (RL4)
    @(posedge sys_clk) disable iff (rst)
    (sup_rise[`PFIF_B_BOOST_THREE] && !pgmask_r[`PFIF_B_BOOST_THREE]) |=>
      ack1_r[`PFIF_B_BOOST_THREE])
    else $error("boost over-voltage flag not set");

  a_ack2_readonly: assert property ( // (RL5)
    @(posedge sys_clk) disable iff (rst)
    (hit(reg_wr, reg_addr, `PFIF_ADDR_ACK2) && !reg_rd &&
     ack2_set == 8'h00) |=> $stable(ack2_r))
    else $error("misc flags changed by a write");

  a_pgmask_excl: assert property ( // (RL6)
    @(posedge sys_clk) disable iff (rst)
    (sup_rise != 8'h00 && ack1_r == 8'h00 && !reg_wr) |=>
      (ack1_r & $past(pgmask_r)) == 8'h00)
    else $error("masked supply reported a fault");

  a_bat_no_int: assert property ( // (RL8)
    @(posedge sys_clk) disable iff (rst)
    ($past(charger_state_reg[6:0]) == charger_state_reg[6:0] &&
     !ack2_r[`PFIF_B_CHARGER] && !reg_rd) |=> !ack2_r[`PFIF_B_CHARGER])
    else $error("battery discharge bit raised a charger flag");

  a_int_follows: assert property ( // (RL9)
    @(posedge sys_clk) disable iff (rst)
    pending |=> !int_n)
    else $error("interrupt not asserted for pending flag");

  a_int_release: assert property ( // (RL7)
    @(posedge sys_clk) disable iff (rst)
    !pending ##1 !pending |-> int_n)
    else $error("interrupt held without pending flag");

endmodule

`default_nettype wire
